// [verilog/nrp_pkg.sv]
`default_nettype none

package nrp_pkg;

   // Bus and block geometry
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned BLK_W = 64;
   localparam int unsigned WORD_SEL_BIT = 2;    // Upper or lower word of a block
   localparam int unsigned HTRANS_ACT_BIT = 1;  // NONSEQ and SEQ both have this bit set
   localparam logic [ADDR_W-1:0] BLK_BYTES = 32'h0000_0008;   // Next sequential block
   localparam logic [ADDR_W-1:0] BLK_MASK = 32'hffff_fff8;    // Clears the byte offset
   localparam logic HRESP_OKAY = 1'h0;

   // Wait-state selection, chosen from the system clock frequency
   localparam logic [1:0] WS_SEL_3 = 2'h0;
   localparam logic [1:0] WS_SEL_1 = 2'h1;
   localparam logic [1:0] WS_SEL_0 = 2'h2;

   // Array read length minus one, per selection
   localparam logic [1:0] RD_LAST_3 = 2'h2;     // Three cycles in the array
   localparam logic [1:0] RD_LAST_1 = 2'h0;     // One cycle in the array
   localparam logic [1:0] RD_LAST_0 = 2'h0;     // Array read cannot be shorter than one cycle

   // Fill engine states
   typedef enum logic {FILL_IDLE, FILL_READ} nrp_fill_e;

   // Captured address phase of one bus transfer
   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [2:0] size;
   } nrp_req_s;

   // Bookkeeping of one read buffer
   typedef struct packed {
      logic valid;                 // Holds a complete block
      logic used;                  // Bus has taken data from it since the fill
      logic [ADDR_W-1:0] tag;      // Byte address of the held block
   } nrp_buf_s;

   // Block address of a byte address
   function automatic logic [ADDR_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
      return a & BLK_MASK;
   endfunction : blk_of

endpackage : nrp_pkg

`default_nettype wire

// [verilog/nrp_prefetch_unit.sv]
// Summary of operation
// (R1) AHB-Lite slave for fetches, reads and writes
// (R2) Array read fills one 64-bit block, three cycles
// (R3) Stall the bus while the block is read
// (R4) Prefetch the next block into the other buffer
// (R5) Buffers swap roles when the next block is taken
// (R6) Non-sequential miss flushes the latest filled buffer
// (R7) Buffered block answered without array read
// (R8) Reads stall while the memory state machine runs
// (R9) Array wait states selectable as three, one, zero; the zero selection reads in one cycle, the same as one
// (R10) Out-of-range addresses get no response
// (R11) Sequential means previous block plus eight bytes
`default_nettype none

module nrp_prefetch_unit #(
   parameter logic [31:0] NVM_BASE = 32'h1100_0000,  // First byte of the array window
   parameter logic [31:0] NVM_SIZE = 32'h0001_0000   // Window length in bytes
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Array read port
   output logic arr_rd,
   output logic [31:0] arr_addr,
   input wire logic [63:0] arr_rdata,
   // Memory state machine and timing control
   input wire logic fsm_busy,
   input wire logic [1:0] ws_sel,
   // Writes forwarded to the assembly buffer logic
   output logic wr_stb,
   output logic [31:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [2:0] wr_size
);

   // Lookup of a block in both buffers: {hit, index}
   function automatic logic [1:0] lookup(input nrp_pkg::nrp_buf_s b0, input nrp_pkg::nrp_buf_s b1,
                                         input logic [31:0] blk);
      if (b0.valid && b0.tag == blk) begin
         return {1'b1, 1'b0};
      end
      if (b1.valid && b1.tag == blk) begin
         return {1'b1, 1'b1};
      end
      return {1'b0, 1'b0};
   endfunction : lookup

   // Address window check, used for bus and prefetch addresses
   function automatic logic in_range(input logic [31:0] a);
      return (a >= NVM_BASE) && (a - NVM_BASE < NVM_SIZE);
   endfunction : in_range

   // Array read length for the selected wait states
   function automatic logic [1:0] rd_last(input logic [1:0] sel);
      unique case (sel)
         nrp_pkg::WS_SEL_3: return nrp_pkg::RD_LAST_3;
         nrp_pkg::WS_SEL_1: return nrp_pkg::RD_LAST_1;
         default: return nrp_pkg::RD_LAST_0;   // Zero selection and the unused code
      endcase
   endfunction : rd_last

   nrp_pkg::nrp_req_s req_q;             // Transfer in its data phase
   nrp_pkg::nrp_buf_s bufs_q [2];        // Buffer bookkeeping
   logic [63:0] data_q [2];              // Buffer contents
   nrp_pkg::nrp_fill_e fill_state_q;     // Fill engine state
   logic [1:0] cnt_q;                    // Array cycles left in the read, minus one
   logic [31:0] fill_blk_q;              // Block being read
   logic fill_buf_q;                     // Buffer being filled
   logic last_fill_q;                    // Buffer filled most recently
   logic act_q;                          // Buffer feeding the bus
   logic [31:0] cur_blk_q;               // Block last served to the bus
   logic cur_valid_q;                    // cur_blk_q is meaningful
   logic wr_stb_q;
   logic [31:0] wr_addr_q;
   logic [31:0] wr_data_q;
   logic [2:0] wr_size_q;

   logic acc, pend_rd, served, dem_miss, dem_start, pf_start, fill_start, fill_done, tgt;
   logic [1:0] a_look, r_look, pf_look;
   logic [31:0] a_blk, r_blk, dem_blk, pf_blk;

   // Address phase acceptance; outside the window nothing reacts
   assign acc = hsel && hready && htrans[nrp_pkg::HTRANS_ACT_BIT] && in_range(haddr);  // R10
   assign a_blk = nrp_pkg::blk_of(haddr);
   assign r_blk = nrp_pkg::blk_of(req_q.addr);
   assign a_look = lookup(bufs_q[0], bufs_q[1], a_blk);
   assign r_look = lookup(bufs_q[0], bufs_q[1], r_blk);

   // Data phase answer; hits while the state machine runs are held too
   assign pend_rd = req_q.valid && !req_q.write;
   assign served = pend_rd && r_look[1] && !fsm_busy;  // R7
   assign hreadyout = !pend_rd || served;  // R3 R8
   assign hresp = nrp_pkg::HRESP_OKAY;  // R1
   assign hrdata = !served ? '0 :
                   req_q.addr[nrp_pkg::WORD_SEL_BIT] ? data_q[r_look[0]][63:32] :
                   data_q[r_look[0]][31:0];

   // Demand fill: a miss is started already in its address phase to save a cycle.
   // A stalled data phase blocks new address phases, so the two sources never meet.
   assign dem_blk = acc ? a_blk : r_blk;
   assign dem_miss = acc ? (!hwrite && !a_look[1]) : (pend_rd && !r_look[1]);
   assign dem_start = dem_miss && !fsm_busy &&  // R8
                      !(fill_state_q == nrp_pkg::FILL_READ && fill_blk_q == dem_blk);

   // Prefetch of the block after the one being served now, else the one last served.
   // Starting in the serving cycle gains a cycle and keeps the base and the
   // target buffer from changing under the request at the same edge.
   assign pf_blk = (served ? r_blk : cur_blk_q) + nrp_pkg::BLK_BYTES;  // R11
   assign pf_look = lookup(bufs_q[0], bufs_q[1], pf_blk);
   assign pf_start = !dem_miss && (served || cur_valid_q) && !fsm_busy && in_range(pf_blk) &&
                     fill_state_q == nrp_pkg::FILL_IDLE && !pf_look[1];  // R4
   assign fill_start = dem_start || pf_start;

   // Target buffer choice
   always_comb begin
      if (pf_start) begin
         // The buffer not feeding the bus after this edge
         tgt = served ? !r_look[0] : !act_q;  // R5
      end else if (fill_state_q == nrp_pkg::FILL_READ) begin
         tgt = fill_buf_q;  // R6
      end else if (bufs_q[0].valid && bufs_q[1].valid && !bufs_q[0].used && !bufs_q[1].used) begin
         tgt = last_fill_q;  // R6
      end else if (!bufs_q[0].valid) begin
         tgt = 1'b0;
      end else if (!bufs_q[1].valid) begin
         tgt = 1'b1;
      end else begin
         tgt = !act_q;   // Keep the buffer the bus is draining
      end
   end

   // A read cut short by a new demand or by the state machine delivers nothing
   assign fill_done = fill_state_q == nrp_pkg::FILL_READ && cnt_q == '0 &&
                      !fill_start && !fsm_busy;  // R2
   assign arr_rd = fill_state_q == nrp_pkg::FILL_READ;
   assign arr_addr = fill_blk_q;

   // Fill engine: one array read at a time
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fill_state_q <= nrp_pkg::FILL_IDLE;
         cnt_q <= '0;
         fill_blk_q <= '0;
         fill_buf_q <= '0;
      end else if (fill_start) begin
         fill_state_q <= nrp_pkg::FILL_READ;
         cnt_q <= rd_last(ws_sel);  // R2 R9
         fill_blk_q <= dem_start ? dem_blk : pf_blk;
         fill_buf_q <= tgt;
      end else if (fsm_busy || (fill_state_q == nrp_pkg::FILL_READ && cnt_q == '0)) begin
         fill_state_q <= nrp_pkg::FILL_IDLE;  // R8
      end else if (fill_state_q == nrp_pkg::FILL_READ) begin
         cnt_q <= cnt_q - 2'h1;
      end
   end

   // Per-buffer state; programming may change the array, so contents are dropped
   for (genvar i = 0; i < 2; i++) begin : g_buf
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            bufs_q[i] <= '0;
         end else if (fsm_busy) begin
            bufs_q[i].valid <= 1'b0;
         end else if (fill_done && fill_buf_q == 1'(i)) begin
            bufs_q[i] <= '{valid: 1'b1, used: 1'b0, tag: fill_blk_q};  // R2
         end else if (fill_start && tgt == 1'(i)) begin
            bufs_q[i].valid <= 1'b0;  // R6
         end else if (served && r_look[0] == 1'(i)) begin
            bufs_q[i].used <= 1'b1;
         end
      end

      // Block data, no reset needed behind the valid bit
      always_ff @(posedge core_clk) begin
         if (fill_done && fill_buf_q == 1'(i)) begin
            data_q[i] <= arr_rdata;
         end
      end
   end

   // Role tracking: the buffer last served becomes the active one
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         act_q <= 1'b0;
         cur_blk_q <= '0;
         cur_valid_q <= 1'b0;
         last_fill_q <= 1'b0;
      end else begin
         if (fsm_busy) begin
            cur_valid_q <= 1'b0;
         end else if (served) begin
            act_q <= r_look[0];  // R5
            cur_blk_q <= r_blk;
            cur_valid_q <= 1'b1;
         end
         if (fill_done) begin
            last_fill_q <= fill_buf_q;
         end
      end
   end

   // Address phase capture, only when the bus moves on
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         req_q <= '0;
      end else if (hready) begin
         req_q <= '{valid: acc, write: hwrite, addr: haddr, size: hsize};  // R1
      end
   end

   // Write data phase ends with zero wait; handed on one cycle later
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wr_stb_q <= 1'b0;
         wr_addr_q <= '0;
         wr_data_q <= '0;
         wr_size_q <= '0;
      end else begin
         wr_stb_q <= req_q.valid && req_q.write && hready;  // R1
         if (req_q.valid && req_q.write && hready) begin
            wr_addr_q <= req_q.addr;
            wr_data_q <= hwdata;
            wr_size_q <= req_q.size;
         end
      end
   end

   assign wr_stb = wr_stb_q;
   assign wr_addr = wr_addr_q;
   assign wr_data = wr_data_q;
   assign wr_size = wr_size_q;

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   a_write_no_wait: assert property (req_q.valid && req_q.write |-> hreadyout ##1 wr_stb) // R1
      else $error("write data phase stalled or not forwarded");
   a_three_cycle_read: assert property ((fill_start && ws_sel == nrp_pkg::WS_SEL_3) ##1
      (!fill_start && !fsm_busy)[*3] |-> fill_done) // R2
      else $error("array read did not finish in three cycles");
   a_no_early_done: assert property (fill_start && ws_sel == nrp_pkg::WS_SEL_3
      |=> !fill_done ##1 !fill_done) // R9
      else $error("array read finished early");
   a_one_cycle_read: assert property ((fill_start && ws_sel == nrp_pkg::WS_SEL_1) ##1
      (!fill_start && !fsm_busy) |-> fill_done) // R9
      else $error("one cycle read not finished");
   a_miss_stalls: assert property (pend_rd && !r_look[1] |-> !hreadyout) // R3
      else $error("miss answered without data");
   a_prefetch_next: assert property (pf_start |=> arr_rd &&
      arr_addr == cur_blk_q + nrp_pkg::BLK_BYTES && fill_buf_q != act_q) // R4
      else $error("prefetch of wrong block or buffer");
   a_flush_latest: assert property (dem_start && fill_state_q == nrp_pkg::FILL_IDLE &&
      bufs_q[0].valid && bufs_q[1].valid && !bufs_q[0].used && !bufs_q[1].used
      |=> fill_buf_q == $past(last_fill_q) && arr_rd) // R6
      else $error("flush did not take latest filled buffer");
   a_hit_no_read: assert property (acc && !hwrite && a_look[1] |-> !dem_start) // R7
      else $error("buffered block read again");
   a_busy_stall: assert property (pend_rd && fsm_busy |-> !hreadyout ##1 !arr_rd) // R8
      else $error("read not held while state machine busy");
   a_out_of_range: assert property (hsel && hready && htrans[nrp_pkg::HTRANS_ACT_BIT] &&
      !in_range(haddr) |=> hreadyout ##1 !wr_stb) // R10
      else $error("reacted to out of range address");

   c_miss_then_hit: cover property (dem_start ##[1:8] served);
   c_role_swap: cover property (served ##[1:16] (served && r_look[0] != act_q));
   c_busy_hold: cover property (pend_rd && fsm_busy ##1 pend_rd && fsm_busy);
   c_flush: cover property (dem_start && fill_state_q == nrp_pkg::FILL_READ);

endmodule : nrp_prefetch_unit

`default_nettype wire

// [tb/nrp_array_model.sv]
`default_nettype none

module nrp_array_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Array read port
   input wire logic arr_rd,
   input wire logic [31:0] arr_addr,
   output logic [63:0] arr_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   logic flip_q; // Idle pattern, so stale data never looks valid

   // Toggle every cycle, whether a read runs or not
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         flip_q <= 1'b0;
      end else begin
         flip_q <= ~flip_q;
      end
   end

   // Whole block derived from its address; only meaningful during a read
   assign arr_rdata = arr_rd ? {arr_addr ^ 32'hc3c3_0000, arr_addr ^ 32'h0000_a5a5}
                             : {64{flip_q}};
endmodule : nrp_array_model

`default_nettype wire

// [tb/nvm_read_prefetch_unit_tb.sv]
`default_nettype none

module nvm_read_prefetch_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [31:0] NVM_BASE = 32'h1100_0000; // Window start handed to the design
   // Bus side stimulus, all valued at time zero
   logic core_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fsm_busy = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [1:0] htrans = 2'h0, ws_sel = 2'h0;
   logic [2:0] hsize = 3'h2;
   // Design and model outputs, bench working values
   logic [31:0] hrdata, arr_addr, wr_addr, wr_data, prev, r;
   logic [2:0] wr_size;
   logic hreadyout, hresp, arr_rd, wr_stb, hready;
   logic [63:0] arr_rdata;
   int num_errors = 0, check_count = 0, seed = 32'h7e19;
   logic [31:0] held[$]; // Blocks the bench expects in the two buffers

   assign hready = hreadyout; // Only slave on this bus

   nrp_prefetch_unit #(.NVM_BASE(NVM_BASE)) u_nrp_prefetch_unit (
      .core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .arr_rd(arr_rd),
      .arr_addr(arr_addr), .arr_rdata(arr_rdata), .fsm_busy(fsm_busy), .ws_sel(ws_sel),
      .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .wr_size(wr_size));

   nrp_array_model u_nrp_array_model (
      .core_clk(core_clk), .rstn(rstn), .arr_rd(arr_rd), .arr_addr(arr_addr),
      .arr_rdata(arr_rdata));

   // Free running 200 MHz clock
   initial begin
      forever #2.5 core_clk = ~core_clk;
   end

   // Compare one value, count and report
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Verdict and end of run
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   // One read; mode 0 exact waits, 1 at least busy+1, 2 at most two
   task automatic rd(input logic [31:0] a, input int busy, input int gap, input int mode);
      logic [31:0] blk;
      int n;
      int want;
      blk = a & nrp_pkg::BLK_MASK;
      want = (ws_sel == nrp_pkg::WS_SEL_3) ? 3 : 1;
      if (held.size() == 2 && (blk == held[0] || blk == held[1])) want = 0;
      hsel = 1'b1;
      haddr = a;
      htrans = 2'b10;
      hwrite = 1'b0;
      fsm_busy = (busy > 0);
      @(posedge core_clk);
      #1 htrans = 2'b00;
      n = 0;
      while (hreadyout !== 1'b1 && n < 200) begin
         @(posedge core_clk);
         #1 n++;
         if (n == busy) fsm_busy = 1'b0;
      end
      check("ready timeout", 32'h1, {31'h0, n < 200});
      check("hrdata", a[2] ? blk ^ 32'hc3c3_0000 : blk ^ 32'h0000_a5a5, hrdata);
      check("hresp", 32'h0, {31'h0, hresp});
      if (mode == 0) check("waits", 32'(want), 32'(n));
      if (mode == 1) check("busy stall", 32'h1, {31'h0, n >= busy + 1});
      if (mode == 2) check("prefetch gain", 32'h1, {31'h0, n <= 2});
      @(posedge core_clk);
      held = {blk, blk + nrp_pkg::BLK_BYTES}; // Served block and its successor
      repeat (gap) begin
         @(posedge core_clk);
      end
      #1;
   endtask : rd

   // One write, forwarded two cycles after its address phase
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      hsel = 1'b1;
      haddr = a;
      htrans = 2'b10;
      hwrite = 1'b1;
      @(posedge core_clk);
      #1 htrans = 2'b00;
      hwdata = d;
      check("wr ready", 32'h1, {31'h0, hreadyout});
      @(posedge core_clk);
      #1;
      check("wr_stb", 32'h1, {31'h0, wr_stb});
      check("wr_addr", a, wr_addr);
      check("wr_data", d, wr_data);
      check("wr_size", {29'h0, hsize}, {29'h0, wr_size});
   endtask : wr

   // Request this module must ignore
   task automatic stray(input logic [31:0] a, input logic sel);
      hsel = sel;
      haddr = a;
      htrans = 2'b10;
      @(posedge core_clk);
      #1 htrans = 2'b00;
      repeat (4) begin
         check("stray ready", 32'h1, {31'h0, hreadyout});
         check("stray read", 32'h0, {31'h0, arr_rd});
         check("stray write", 32'h0, {31'h0, wr_stb});
         @(posedge core_clk);
         #1;
      end
      hsel = 1'b0;
   endtask : stray

   // Hang guard, far beyond the expected run length
   initial begin
      #100_000;
      num_errors++;
      wrap_up();
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      check("reset ready", 32'h1, {31'h0, hreadyout});
      #1 rstn = 1'b1;
      // Every wait selection: miss, same block, next block
      for (int w = 0; w < 4; w++) begin
         ws_sel = 2'(w);
         prev = NVM_BASE + 32'(w * 256) + 32'h4;
         rd(prev, 0, 8, 0);
         rd(prev - 32'h4, 0, 8, 0);
         rd(prev + 32'h4, 0, 8, 0);
      end
      // Back to back sequential blocks, then a jump away
      ws_sel = nrp_pkg::WS_SEL_3;
      rd(NVM_BASE + 32'h800, 0, 0, 0);
      rd(NVM_BASE + 32'h808, 0, 0, 2);
      rd(NVM_BASE + 32'h900, 0, 8, 0);
      rd(NVM_BASE + 32'h904, 12, 8, 1);
      // Random mix of repeats, successors and jumps
      prev = NVM_BASE + 32'h2000;
      repeat (30) begin
         r = $random(seed);
         ws_sel = r[17:16];
         case (r[1:0])
            2'h0: prev = prev + 32'h8;
            2'h1: prev = prev ^ 32'h4;
            default: prev = NVM_BASE + {18'h0, r[13:4], 4'h0};
         endcase
         rd(prev, 0, 8, 0);
      end
      repeat (4) begin
         r = $random(seed);
         hsize = {1'b0, r[20], ~r[20]};
         wr(NVM_BASE + {16'h0, r[15:2], 2'b00}, $random(seed));
      end
      stray(32'h2000_0000, 1'b1);
      stray(NVM_BASE + 32'h100, 1'b0);
      wrap_up();
   end
endmodule : nvm_read_prefetch_unit_tb

`default_nettype wire
